// >>> bsw_regs.svh
`ifndef BSW_REGS_SVH
`define BSW_REGS_SVH

// ************************************************************
// Address map
// ************************************************************
`define BSW_ADDR_W 16
`define BSW_ROM_LO 16'h0000
`define BSW_ROM_HI 16'h27ff
`define BSW_ROM_MIR_LO 16'h8000
`define BSW_ROM_MIR_HI 16'ha7ff
`define BSW_RAM_LO 16'h0000
`define BSW_RAM_HI 16'h3fff
`define BSW_IO_LO 16'hf800
`define BSW_IO_HI 16'hffff
`define BSW_OFF_W 14

// ************************************************************
// Register offsets and fields
// ************************************************************
`define BSW_SHADOW_CFG_ADDR 16'hff90
`define BSW_WDCS_ADDR 16'hff93
`define BSW_USB_CTRL_ADDR 16'hfffc
`define BSW_SHADOW_BIT 0
`define BSW_CODE_SIZE_VAL 2'h2
`define BSW_CODE_RAM_VAL 1'h1
`define BSW_WD_SERVICE_BIT 0
`define BSW_WD_FLAG_BIT 6
`define BSW_WD_LOW_BIT 7
`define BSW_USB_CONNECT_BIT 7
`define BSW_WD_DIS_UPPER_KEY 5'h15
`define BSW_WD_DIS_LOW_KEY 1'h0
`define BSW_WD_UPPER_RST 5'h00
`define BSW_WD_LOW_RST 1'h1

// ************************************************************
// Timing
// ************************************************************
`define BSW_CLK_PERIOD_NS 8
`define BSW_CORE_RST_NS 128
`define BSW_RST_HOLD_CYC ((`BSW_CORE_RST_NS + `BSW_CLK_PERIOD_NS - 1) / `BSW_CLK_PERIOD_NS)
`define BSW_WD_BITS 7
`endif

// >>> bsw_pkg.sv
package bsw_pkg;
  // Gray sequence along the usual path: run, then watchdog hold.
  typedef enum logic [1:0] {
    BSW_RUN = 2'h0,
    BSW_HOLD = 2'h1
  } bsw_phase_t;

  typedef struct packed {
    logic [15:0] addr;
    logic fetch;
  } bsw_cbus_t;

  typedef struct packed {
    logic [15:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } bsw_xbus_t;

  typedef struct packed {
    logic code_rom;
    logic code_ram;
    logic [13:0] code_off;
    logic data_ram;
    logic data_ram_we;
    logic data_io;
    logic [13:0] data_off;
  } bsw_dec_t;

  typedef struct packed {
    logic [15:0] count;
    logic expire;
  } bsw_wd_t;
endpackage

// >>> bsw_wdog.sv
`include "bsw_regs.svh"
module bsw_wdog #(
  parameter int WD_BITS = `BSW_WD_BITS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic run,
  input wire logic clear,
  output logic [WD_BITS-1:0] count,
  output logic expire
);
  bsw_pkg::bsw_wd_t st_ff;
  bsw_pkg::bsw_wd_t nxt_st;
  localparam logic [WD_BITS-1:0] WD_MAX = {WD_BITS{1'b1}};

  initial begin
    if (WD_BITS < 1 || WD_BITS > 16) begin
      $error("bsw_wdog: WD_BITS must lie in 1..16");
    end
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.expire = 1'b0;
    if (clear) begin
      nxt_st.count = 16'h0000;
    end else if (run && tick) begin
      if (st_ff.count[WD_BITS-1:0] == WD_MAX) begin
        // 2**WD_BITS ticks without service: one-cycle time-out pulse.
        nxt_st.count = 16'h0000;
        nxt_st.expire = 1'b1;
      end else begin
        nxt_st.count = st_ff.count + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign count = st_ff.count[WD_BITS-1:0];
  assign expire = st_ff.expire;
endmodule

// >>> bsw_top.sv
`include "bsw_regs.svh"
module bsw_top #(
  parameter int WD_BITS = `BSW_WD_BITS,
  parameter int RST_HOLD = `BSW_RST_HOLD_CYC
) (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire bsw_pkg::bsw_cbus_t CBUS,
  input wire bsw_pkg::bsw_xbus_t XBUS,
  input wire logic SOF_PULSE,
  output bsw_pkg::bsw_dec_t DEC,
  output logic [7:0] XRDATA,
  output logic CORE_RST,
  output logic SHADOW_ENABLE,
  output logic USB_CONNECT
);

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  initial begin
    if (RST_HOLD < 1 || RST_HOLD > 255) begin
      $error("bsw_top: RST_HOLD must lie in 1..255");
    end
    if (WD_BITS < 1 || WD_BITS > 16) begin
      $error("bsw_top: WD_BITS must lie in 1..16");
    end
  end

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    bsw_pkg::bsw_phase_t phase;
    logic [7:0] hold_cnt;
    logic core_rst;
    logic shadow_enable;
    logic usb_connect;
    logic [4:0] wd_disable_upper;
    logic wd_disable_low;
    logic wd_reset_flag;
    logic [7:0] rdata;
    bsw_pkg::bsw_dec_t dec;
  } bsw_top_state_t;

  bsw_top_state_t st_ff;
  bsw_top_state_t nxt_st;

  localparam logic [7:0] HOLD_LAST = 8'(RST_HOLD - 1);

  logic wd_expire;
  logic wd_run;
  logic wd_clear;
  logic wr_shadow_cfg;
  logic wr_wdcs;
  logic wr_usb_ctrl;
  logic bus_live;

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic in_window(
    input logic [15:0] addr,
    input logic [15:0] lo,
    input logic [15:0] hi
  );
    in_window = (addr >= lo) && (addr <= hi);
  endfunction

  function automatic logic wd_disabled(
    input logic [4:0] upper,
    input logic low
  );
    wd_disabled = (upper == `BSW_WD_DIS_UPPER_KEY) && (low == `BSW_WD_DIS_LOW_KEY);
  endfunction

  function automatic logic [7:0] shadow_cfg_value(input logic shadow);
    // Size and memory-type fields are wired constants, untouched by any reset.
    shadow_cfg_value = {`BSW_CODE_RAM_VAL, `BSW_CODE_SIZE_VAL, 4'h0, shadow};
  endfunction

  // ************************************************************
  // Register write strobes
  // ************************************************************
  // Writes are ignored while the core is held in watchdog reset.
  assign bus_live = (st_ff.phase == bsw_pkg::BSW_RUN);
  assign wr_shadow_cfg = bus_live && XBUS.wr && (XBUS.addr == `BSW_SHADOW_CFG_ADDR);
  assign wr_wdcs = bus_live && XBUS.wr && (XBUS.addr == `BSW_WDCS_ADDR);
  assign wr_usb_ctrl = bus_live && XBUS.wr && (XBUS.addr == `BSW_USB_CTRL_ADDR);

  // ************************************************************
  // Watchdog
  // ************************************************************
  assign wd_run = st_ff.usb_connect && !wd_disabled(st_ff.wd_disable_upper, st_ff.wd_disable_low);
  assign wd_clear = (wr_wdcs && XBUS.wdata[`BSW_WD_SERVICE_BIT]) || !bus_live;

  bsw_wdog #(
    .WD_BITS(WD_BITS)
  ) u_wdog (
    .clk(CLOCK),
    .rst(SYS_RST),
    .tick(SOF_PULSE),
    .run(wd_run),
    .clear(wd_clear),
    .count(),
    .expire(wd_expire)
  );

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rdata = 8'h00;
    unique case (st_ff.phase)
      bsw_pkg::BSW_RUN: begin
        nxt_st.core_rst = 1'b0;
        if (wd_expire) begin
          // Time-out acts as a device reset, except that it leaves the flag set.
          nxt_st.phase = bsw_pkg::BSW_HOLD;
          nxt_st.hold_cnt = 8'h00;
          nxt_st.core_rst = 1'b1;
          nxt_st.shadow_enable = 1'b0;
          nxt_st.usb_connect = 1'b0;
          nxt_st.wd_disable_upper = `BSW_WD_UPPER_RST;
          nxt_st.wd_disable_low = `BSW_WD_LOW_RST;
          nxt_st.wd_reset_flag = 1'b1;
        end else begin
          if (wr_shadow_cfg && XBUS.wdata[`BSW_SHADOW_BIT]) begin
            // Writing zero cannot leave normal mode; only resets do that.
            nxt_st.shadow_enable = 1'b1;
          end
          if (wr_usb_ctrl) begin
            nxt_st.usb_connect = XBUS.wdata[`BSW_USB_CONNECT_BIT];
          end
          if (wr_wdcs) begin
            nxt_st.wd_disable_upper = XBUS.wdata[5:1];
            nxt_st.wd_disable_low = XBUS.wdata[`BSW_WD_LOW_BIT];
            if (XBUS.wdata[`BSW_WD_FLAG_BIT]) begin
              nxt_st.wd_reset_flag = 1'b0;
            end
          end
          if (XBUS.rd) begin
            if (XBUS.addr == `BSW_SHADOW_CFG_ADDR) begin
              nxt_st.rdata = shadow_cfg_value(st_ff.shadow_enable);
            end else if (XBUS.addr == `BSW_WDCS_ADDR) begin
              // The service bit has no storage and always reads as zero.
              nxt_st.rdata = {st_ff.wd_disable_low, st_ff.wd_reset_flag,
                              st_ff.wd_disable_upper, 1'b0};
            end else if (XBUS.addr == `BSW_USB_CTRL_ADDR) begin
              nxt_st.rdata = {st_ff.usb_connect, 7'h00};
            end
          end
        end
      end
      bsw_pkg::BSW_HOLD: begin
        nxt_st.core_rst = 1'b1;
        if (st_ff.hold_cnt == HOLD_LAST) begin
          nxt_st.phase = bsw_pkg::BSW_RUN;
          nxt_st.core_rst = 1'b0;
          nxt_st.hold_cnt = 8'h00;
        end else begin
          nxt_st.hold_cnt = st_ff.hold_cnt + 8'h01;
        end
      end
      default: begin
        nxt_st.phase = bsw_pkg::BSW_HOLD;
        nxt_st.hold_cnt = 8'h00;
        nxt_st.core_rst = 1'b1;
      end
    endcase

    // ************************************************************
    // Address decode
    // ************************************************************
    // The decode follows the shadow bit as it stands now; the core should
    // not depend on the map in the same cycle as its write to the bit.
    nxt_st.dec.code_off = CBUS.addr[13:0];
    nxt_st.dec.data_off = XBUS.addr[13:0];
    nxt_st.dec.code_rom = 1'b0;
    nxt_st.dec.code_ram = 1'b0;
    if (CBUS.fetch) begin
      if (in_window(CBUS.addr, `BSW_ROM_MIR_LO, `BSW_ROM_MIR_HI)) begin
        nxt_st.dec.code_rom = 1'b1;
      end else if (!st_ff.shadow_enable) begin
        nxt_st.dec.code_rom = in_window(CBUS.addr, `BSW_ROM_LO, `BSW_ROM_HI);
      end else begin
        nxt_st.dec.code_ram = in_window(CBUS.addr, `BSW_RAM_LO, `BSW_RAM_HI);
      end
    end
    nxt_st.dec.data_ram = 1'b0;
    nxt_st.dec.data_ram_we = 1'b0;
    nxt_st.dec.data_io = 1'b0;
    if (XBUS.rd || XBUS.wr) begin
      nxt_st.dec.data_io = in_window(XBUS.addr, `BSW_IO_LO, `BSW_IO_HI);
      if (!st_ff.shadow_enable && in_window(XBUS.addr, `BSW_RAM_LO, `BSW_RAM_HI)) begin
        nxt_st.dec.data_ram = 1'b1;
        nxt_st.dec.data_ram_we = XBUS.wr && bus_live;
      end
    end
    if (!bus_live || nxt_st.core_rst) begin
      nxt_st.dec.code_rom = 1'b0;
      nxt_st.dec.code_ram = 1'b0;
      nxt_st.dec.data_ram = 1'b0;
      nxt_st.dec.data_ram_we = 1'b0;
      nxt_st.dec.data_io = 1'b0;
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      // Power-up: boot map, disconnected, watchdog armed, flag clear.
      st_ff.phase <= bsw_pkg::BSW_HOLD;
      st_ff.hold_cnt <= 8'h00;
      st_ff.core_rst <= 1'b1;
      st_ff.shadow_enable <= 1'b0;
      st_ff.usb_connect <= 1'b0;
      st_ff.wd_disable_upper <= `BSW_WD_UPPER_RST;
      st_ff.wd_disable_low <= `BSW_WD_LOW_RST;
      st_ff.wd_reset_flag <= 1'b0;
      st_ff.rdata <= 8'h00;
      st_ff.dec <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign DEC = st_ff.dec;
  assign XRDATA = st_ff.rdata;
  assign CORE_RST = st_ff.core_rst;
  assign SHADOW_ENABLE = st_ff.shadow_enable;
  assign USB_CONNECT = st_ff.usb_connect;
endmodule

// >>> bsw_top_assertions.sv
module bsw_top_assertions #(
  parameter int WD_BITS = 7,
  parameter int RST_HOLD = 16
) (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire bsw_pkg::bsw_cbus_t CBUS,
  input wire bsw_pkg::bsw_xbus_t XBUS,
  input wire logic SOF_PULSE,
  input wire bsw_pkg::bsw_dec_t DEC,
  input wire logic [7:0] XRDATA,
  input wire logic CORE_RST,
  input wire logic SHADOW_ENABLE,
  input wire logic USB_CONNECT
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // Port checks
  // ****************
  wire logic acc = (XBUS.rd || XBUS.wr) && !CORE_RST;
  wire logic fet = CBUS.fetch && !CORE_RST;
  wire logic [13:0] coff = CBUS.addr[13:0];
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  cfg_read_a:
    assert property (acc && XBUS.rd && XBUS.addr == 16'hff90 |=> XRDATA[7:1] == 7'h60) else $error("config read");
  svc_read_a:
    assert property (acc && XBUS.rd && XBUS.addr == 16'hff93 |=> !XRDATA[0]) else $error("service bit read");
  shadow_set_a:
    assert property (acc && XBUS.wr && XBUS.addr == 16'hff90 && XBUS.wdata[0] |=> SHADOW_ENABLE)
      else $error("shadow not set");
  shadow_hold_a:
    assert property ($fell(SHADOW_ENABLE) |-> CORE_RST) else $error("shadow cleared");
  tick_only_a:
    assert property (!SOF_PULSE |-> ##2 !$rose(CORE_RST)) else $error("reset without tick");
  boot_rom_a:
    assert property (fet && !SHADOW_ENABLE && (CBUS.addr <= 16'h27ff || (CBUS.addr >= 16'h8000 &&
      CBUS.addr <= 16'ha7ff)) |=> DEC.code_rom && DEC.code_off == $past(coff)) else $error("boot rom");
  code_ram_a:
    assert property (fet && SHADOW_ENABLE && CBUS.addr <= 16'h3fff |=> DEC.code_ram && !DEC.code_rom)
      else $error("code ram");
  data_ram_a:
    assert property (acc && !SHADOW_ENABLE && XBUS.addr <= 16'h3fff |=> DEC.data_ram &&
      DEC.data_ram_we == $past(XBUS.wr)) else $error("data ram");
  no_data_ram_a:
    assert property (DEC.data_ram |-> !$past(SHADOW_ENABLE)) else $error("data ram in normal");
  io_decode_a:
    assert property (acc && XBUS.addr[15:11] == 5'h1f |=> DEC.data_io) else $error("io decode");
  wd_clear_a:
    assert property ($rose(CORE_RST) |=> !SHADOW_ENABLE && !USB_CONNECT) else $error("reset clear");
endmodule
bind bsw_top bsw_top_assertions #(.WD_BITS(WD_BITS), .RST_HOLD(RST_HOLD)) chk (.CLOCK(CLOCK),
  .SYS_RST(SYS_RST), .CBUS(CBUS), .XBUS(XBUS), .SOF_PULSE(SOF_PULSE), .DEC(DEC), .XRDATA(XRDATA),
  .CORE_RST(CORE_RST), .SHADOW_ENABLE(SHADOW_ENABLE), .USB_CONNECT(USB_CONNECT));

// >>> bsw_core_model.sv
module bsw_core_model (
  input wire logic clk,
  input wire logic core_rst,
  input wire logic req,
  input wire logic [15:0] req_addr,
  output bsw_pkg::bsw_cbus_t cbus
);
  timeunit 1ns;
  timeprecision 1ps;
  logic boot_ff = 1'b1;
  initial cbus = '0;
  // The address is inverted while idle so a decoder that ignores fetch is caught.
  always @(posedge clk) begin
    if (core_rst) begin
      boot_ff <= 1'b1;
      cbus <= '0;
    end else begin
      boot_ff <= 1'b0;
      cbus.fetch <= boot_ff | req;
      cbus.addr <= boot_ff ? 16'h0000 : (req ? req_addr : ~req_addr);
    end
  end
endmodule

// >>> test_boot_shadow_map_and_watchdog.sv
module test_boot_shadow_map_and_watchdog;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RH = 2;
  localparam int WB = 3;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic sof = 1'b0;
  logic req = 1'b0;
  logic [15:0] req_addr = 16'h0000;
  bsw_pkg::bsw_xbus_t xbus = '0;
  bsw_pkg::bsw_cbus_t cbus;
  bsw_pkg::bsw_dec_t dec;
  bsw_pkg::bsw_dec_t dq;
  logic [7:0] xrdata;
  logic [7:0] d;
  logic core_rst;
  logic shadow;
  logic connect;
  logic [15:0] fa [6] = '{16'h0000, 16'h27ff, 16'h2800, 16'h8000, 16'ha7ff, 16'ha800};
  logic [5:0] rom_hit = 6'b011011;
  int bad_count = 0;
  int check_count = 0;
  `define CHK(a, e) begin check_count++; if ((a) !== (e)) begin bad_count++; \
    $display("Error %0t: %h not %h", $time, a, e); end end
  always #4 clock = ~clock;
  bsw_top #(.WD_BITS(WB), .RST_HOLD(RH)) dut (.CLOCK(clock), .SYS_RST(sys_rst), .CBUS(cbus), .XBUS(xbus),
    .SOF_PULSE(sof), .DEC(dec), .XRDATA(xrdata), .CORE_RST(core_rst), .SHADOW_ENABLE(shadow),
    .USB_CONNECT(connect));
  bsw_core_model core (.clk(clock), .core_rst(core_rst), .req(req), .req_addr(req_addr), .cbus(cbus));
  // ****************
  // Access tasks
  // ****************
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clock) xbus <= {a, 2'b01, v};
    @(posedge clock) xbus <= '0;
    #1 dq = dec;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(posedge clock) xbus <= {a, 2'b10, 8'h00};
    @(posedge clock) xbus <= '0;
    #1 v = xrdata;
    dq = dec;
  endtask
  // The core model adds one cycle, so the answer lands two edges after the request is raised.
  task automatic fe(input logic [15:0] a);
    @(posedge clock) req <= 1'b1;
    req_addr <= a;
    @(posedge clock) req <= 1'b0;
    @(posedge clock) #1 dq = dec;
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clock) sof <= 1'b1;
      @(posedge clock) sof <= 1'b0;
    end
  endtask
  task automatic settle();
    repeat (RH + 3) @(posedge clock);
    #1 `CHK(core_rst, 1'b0)
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clock);
    bad_count++;
    final_report();
  end
  initial begin
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    settle();
    rd(16'hff90, d); `CHK(d, 8'hc0)
    rd(16'hff93, d); `CHK(d, 8'h80)
    rd(16'hfffc, d); `CHK(d, 8'h00)
    rd(16'hff91, d); `CHK(d, 8'h00)
    wr(16'hff90, 8'h7e);
    rd(16'hff90, d); `CHK(d, 8'hc0)
    $display("test 1 done");
    for (int i = 0; i < 6; i++) begin
      fe(fa[i]); `CHK(dq.code_rom, rom_hit[i])
    end
    fe(16'ha7ff); `CHK(dq.code_off, 14'h27ff)
    wr(16'h0100, 8'h55); `CHK({dq.data_ram, dq.data_ram_we}, 2'b11)
    rd(16'h3fff, d); `CHK({dq.data_ram, dq.data_ram_we}, 2'b10)
    `CHK(dq.data_off, 14'h3fff)
    rd(16'hf800, d); `CHK(dq.data_io, 1'b1)
    ticks(9); `CHK(core_rst, 1'b0)
    $display("test 2 done");
    wr(16'hff90, 8'h01); `CHK(shadow, 1'b1)
    wr(16'hff90, 8'h00); `CHK(shadow, 1'b1)
    fe(16'h0000); `CHK({dq.code_ram, dq.code_rom}, 2'b10)
    fe(16'h8000); `CHK({dq.code_ram, dq.code_rom}, 2'b01)
    wr(16'h0010, 8'haa); `CHK({dq.data_ram, dq.data_io}, 2'b00)
    rd(16'hfff0, d); `CHK(dq.data_io, 1'b1)
    wr(16'hfffc, 8'h80); `CHK(connect, 1'b1)
    $display("test 3 done");
    wr(16'hff93, 8'h2a);
    rd(16'hff93, d); `CHK(d, 8'h2a)
    ticks(10); `CHK(core_rst, 1'b0)
    wr(16'hff93, 8'h80);
    ticks(7);
    wr(16'hff93, 8'h81);
    ticks(7);
    wr(16'hff93, 8'h80); `CHK(core_rst, 1'b0)
    ticks(1);
    #1 `CHK(core_rst, 1'b0)
    @(posedge clock) #1 `CHK(core_rst, 1'b1)
    $display("test 4 done");
    settle(); `CHK({shadow, connect}, 2'b00)
    rd(16'hff93, d); `CHK(d, 8'hc0)
    wr(16'hff93, 8'h80);
    rd(16'hff93, d); `CHK(d, 8'hc0)
    wr(16'hff93, 8'hc0);
    rd(16'hff93, d); `CHK(d, 8'h80)
    rd(16'hff90, d); `CHK(d, 8'hc0)
    fe(16'h0000); `CHK(dq.code_rom, 1'b1)
    $display("test 5 done");
    final_report();
  end
endmodule
